/* File: verilog/tsr_pkg.sv */
// shared constants, types and format helpers for the temperature sensor register bank
package tsr_pkg;

  // ==========================================================
  // clock and conversion timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned RATE_MS_0 = 4000; // 0.25 Hz
  localparam int unsigned RATE_MS_1 = 1000; // 1 Hz
  localparam int unsigned RATE_MS_2 = 250; // 4 Hz
  localparam int unsigned RATE_MS_3 = 125; // 8 Hz
  localparam int unsigned TIMER_W = 28;

  // ==========================================================
  // register index codes
  localparam logic [1:0] IDX_TEMP = 2'h0;
  localparam logic [1:0] IDX_MODE = 2'h1;
  localparam logic [1:0] IDX_LOW = 2'h2;
  localparam logic [1:0] IDX_HIGH = 2'h3;
  localparam logic [7:0] INDEX_RESET = 8'h00;

  // ==========================================================
  // mode control byte fields and reset values
  localparam int unsigned HB_SHOT = 7;
  localparam int unsigned HB_FAULT_LO = 3;
  localparam int unsigned HB_POL = 2;
  localparam int unsigned HB_TM = 1;
  localparam int unsigned HB_PD = 0;
  localparam int unsigned LB_RATE_LO = 6;
  localparam int unsigned LB_WIDE = 4;
  localparam logic [15:0] MODE_RESET = 16'h60a0;
  localparam logic [1:0] RES_FIXED = 2'h3;
  localparam logic [1:0] RATE_RESET = 2'h2;
  localparam logic [15:0] UPPER_RESET = 16'h5000; // +80 C
  localparam logic [15:0] LOWER_RESET = 16'h4b00; // +75 C

  // ==========================================================
  // link events and converter states
  typedef enum logic [2:0] {
    EV_INDEX = 3'h0,
    EV_WR_MSB = 3'h1,
    EV_WR_LSB = 3'h2,
    EV_READ = 3'h3,
    EV_ALERT_RESP = 3'h4
  } tsr_kind_e;

  typedef struct packed {
    tsr_kind_e kind;
    logic [7:0] data;
  } tsr_evt_s;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_CONV = 3'b010,
    ST_SLEEP = 3'b100
  } tsr_state_e;

  // ==========================================================
  // left-justified word to signed count
  function automatic logic signed [12:0] to_count(input logic [15:0] w, input logic wide);
    to_count = wide ? w[15:3] : {w[15], w[15:4]};
  endfunction

  // signed count to left-justified word; wide format marks bit 0
  function automatic logic [15:0] to_word(input logic signed [12:0] c, input logic wide);
    to_word = wide ? {c, 3'h1} : {c[11:0], 4'h0};
  endfunction

  // consecutive faults needed per fault count code
  function automatic logic [2:0] fault_need(input logic [1:0] sel);
    case (sel)
      2'h0: fault_need = 3'h1;
      2'h1: fault_need = 3'h2;
      2'h2: fault_need = 3'h4;
      default: fault_need = 3'h6;
    endcase
  endfunction

endpackage

/* File: verilog/tsr_bank.sv */
// temperature sensor register bank with link-clock byte port and conversion scheduler
// Notes on behaviour
// - eight-bit index selects the accessed register
// - index 0 temp, 1 mode, 2 low, 3 high
// - index clears to zero at power-up
// - result read-only, 12 or 13 bits
// - reads return high byte then low byte
// - result left-justified; wide format sets bit 0
// - mode control sixteen bits, high byte first
// - mode field layout, reset 0x60a0
// - each byte stored as it arrives
// - power-down stops after current conversion
// - select bit: comparator or interrupt flag
// - polarity bit inverts the flag pin
// - flag only after consecutive limit faults
// - fault code gives one, two, four, six
// - resolution bits read fixed 11
// - single shot write with power-down bit set starts one conversion
// - shot bit reads 0 while a shot conversion runs
// - wide format applies to result and limits
// - rate field selects conversion period
// - flag status follows comparator, polarity applied
// - interrupt flag cleared by read, response, power-down
// - limits compared each conversion, reset 80/75
`timescale 1ns/100ps
module tsr_bank
  import tsr_pkg::*;
#(
  parameter int unsigned RATE0_CYC = RATE_MS_0 * CYC_PER_MS,
  parameter int unsigned RATE1_CYC = RATE_MS_1 * CYC_PER_MS,
  parameter int unsigned RATE2_CYC = RATE_MS_2 * CYC_PER_MS,
  parameter int unsigned RATE3_CYC = RATE_MS_3 * CYC_PER_MS
) (
  input wire logic mclk, // system clock
  input wire logic reset, // async reset, high
  input wire logic conv_done, // converter result valid pulse
  input wire logic signed [12:0] conv_value, // converter count, 1/16 degree
  output logic conv_start, // converter start pulse
  output logic flag_out, // threshold flag pin level
  input wire logic lk_clk, // link clock
  input wire logic lk_start, // transaction start pulse
  input wire logic lk_read, // with lk_start: read transaction
  input wire logic lk_wr_valid, // written byte valid pulse
  input wire logic [7:0] lk_wr_byte, // written byte
  input wire logic lk_rd_next, // host took current read byte
  input wire logic lk_alert_resp, // alert response answered
  output logic lk_ready, // link may issue next item
  output logic [7:0] lk_rd_data // byte offered to a read
);

  // ==========================================================
  // link domain: byte sequencing and event launch
  logic req_t;
  logic ack_s1;
  logic ack_s2;
  tsr_evt_s evt;
  logic [1:0] wcnt;
  logic rd_pend;
  logic rd_phase;
  logic [15:0] rd_word_lk;
  logic ack_t;
  logic [15:0] rd_hold;

  // one event in flight; far end waits on lk_ready
  wire lk_idle = (req_t == ack_s2);
  wire iss_read = lk_ready & lk_start & lk_read;
  wire iss_wr = lk_ready & lk_wr_valid & (wcnt != 2'h3) & ~iss_read;
  wire iss_ar = lk_ready & lk_alert_resp & ~iss_read & ~iss_wr;
  wire lk_issue = iss_read | iss_wr | iss_ar;
  wire tsr_kind_e wr_kind = (wcnt == 2'h0) ? EV_INDEX :
                            (wcnt == 2'h1) ? EV_WR_MSB : EV_WR_LSB;
  wire tsr_kind_e next_kind = iss_read ? EV_READ : iss_wr ? wr_kind : EV_ALERT_RESP;

  // ack synchroniser
  always_ff @(posedge lk_clk or posedge reset) begin
    if (reset) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      ack_s1 <= ack_t;
      ack_s2 <= ack_s1;
    end
  end

  // launch events, count write bytes
  always_ff @(posedge lk_clk or posedge reset) begin
    if (reset) begin
      req_t <= 1'b0;
      evt <= '{kind: EV_INDEX, data: 8'h00};
      wcnt <= 2'h0;
      lk_ready <= 1'b0;
    end else begin
      req_t <= req_t ^ lk_issue;
      if (lk_issue) begin
        evt <= '{kind: next_kind, data: lk_wr_byte};
      end
      if (lk_start & ~lk_read) begin
        wcnt <= 2'h0;
      end else if (iss_wr) begin
        wcnt <= wcnt + 2'h1;
      end
      lk_ready <= ~lk_issue & lk_idle & ~rd_pend;
    end
  end

  // high byte first, then low byte
  always_ff @(posedge lk_clk or posedge reset) begin
    if (reset) begin
      rd_pend <= 1'b0;
      rd_phase <= 1'b0;
      rd_word_lk <= 16'h0000;
      lk_rd_data <= 8'h00;
    end else if (iss_read) begin
      rd_pend <= 1'b1;
    end else if (rd_pend & lk_idle) begin
      rd_pend <= 1'b0;
      rd_phase <= 1'b0;
      rd_word_lk <= rd_hold; // stable once ack seen
      lk_rd_data <= rd_hold[15:8];
    end else if (lk_rd_next) begin
      rd_phase <= ~rd_phase;
      lk_rd_data <= rd_phase ? rd_word_lk[15:8] : rd_word_lk[7:0];
    end
  end

  // ==========================================================
  // main domain: event receive
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic [7:0] index;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [15:0] temperature_result;
  logic shot_rd;
  logic [1:0] fault_sel;
  logic flag_pin_polarity;
  logic tm;
  logic pd;
  logic [1:0] rate;
  logic wide;
  logic shot_req;

  // request synchroniser plus edge stage
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end else begin
      req_s1 <= req_t;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // event decode
  wire ev = req_s2 ^ req_s3;
  wire [7:0] ev_d = evt.data;
  wire ev_index = ev & (evt.kind == EV_INDEX);
  wire ev_msb = ev & (evt.kind == EV_WR_MSB);
  wire ev_lsb = ev & (evt.kind == EV_WR_LSB);
  wire ev_read = ev & (evt.kind == EV_READ);
  wire ev_ar = ev & (evt.kind == EV_ALERT_RESP);
  // two low index bits select the register
  wire [1:0] sel = index[1:0];
  wire mode_msb = ev_msb & (sel == IDX_MODE);
  wire mode_lsb = ev_lsb & (sel == IDX_MODE);
  wire pd_rise = mode_msb & ev_d[HB_PD] & ~pd;
  wire shot_set = mode_msb & ev_d[HB_SHOT] & ev_d[HB_PD];

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      index <= INDEX_RESET;
      ack_t <= 1'b0;
    end else begin
      ack_t <= ack_t ^ ev;
      if (ev_index) begin
        index <= ev_d;
      end
    end
  end

  // limits stored byte by byte, reset values
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      upper_limit <= UPPER_RESET;
      lower_limit <= LOWER_RESET;
    end else begin
      if (ev_msb & (sel == IDX_HIGH)) upper_limit[15:8] <= ev_d;
      if (ev_lsb & (sel == IDX_HIGH)) upper_limit[7:0] <= ev_d;
      if (ev_msb & (sel == IDX_LOW)) lower_limit[15:8] <= ev_d;
      if (ev_lsb & (sel == IDX_LOW)) lower_limit[7:0] <= ev_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fault_sel <= MODE_RESET[12:11];
      flag_pin_polarity <= MODE_RESET[10];
      tm <= MODE_RESET[9];
      pd <= MODE_RESET[8];
      rate <= RATE_RESET;
      wide <= MODE_RESET[4];
    end else begin
      if (mode_msb) begin
        fault_sel <= ev_d[HB_FAULT_LO +: 2];
        flag_pin_polarity <= ev_d[HB_POL];
        tm <= ev_d[HB_TM];
        pd <= ev_d[HB_PD];
      end
      if (mode_lsb) begin
        rate <= ev_d[LB_RATE_LO +: 2];
        wide <= ev_d[LB_WIDE];
      end
    end
  end

  // ==========================================================
  // conversion scheduler
  tsr_state_e st;
  tsr_state_e next_st;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic next_start;
  logic shot_busy;
  logic next_busy;

  wire [TIMER_W-1:0] period = (rate == 2'h0) ? TIMER_W'(RATE0_CYC) :
                              (rate == 2'h1) ? TIMER_W'(RATE1_CYC) :
                              (rate == 2'h2) ? TIMER_W'(RATE2_CYC) : TIMER_W'(RATE3_CYC);
  wire conv_fin = (st == ST_CONV) & conv_done;
  wire shot_take = (st == ST_SLEEP) & shot_req;

  always_comb begin
    next_st = st;
    next_timer = (timer == '0) ? '0 : timer - TIMER_W'(1);
    next_start = 1'b0;
    next_busy = shot_busy;
    case (st)
      ST_WAIT: begin
        if (pd) begin
          next_st = ST_SLEEP;
        end else if (timer == '0) begin
          next_start = 1'b1;
          next_st = ST_CONV;
          next_timer = period - TIMER_W'(1);
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          next_st = (pd | shot_busy) ? ST_SLEEP : ST_WAIT;
          next_busy = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (shot_req) begin
          next_start = 1'b1;
          next_st = ST_CONV;
          next_busy = 1'b1;
        end else if (~pd) begin
          next_st = ST_WAIT;
        end
      end
      default: begin
        next_st = ST_WAIT;
      end
    endcase
  end

  // scheduler registers; power-up starts at once
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st <= ST_WAIT;
      timer <= '0;
      conv_start <= 1'b0;
      shot_busy <= 1'b0;
    end else begin
      st <= next_st;
      timer <= next_timer;
      conv_start <= next_start;
      shot_busy <= next_busy;
    end
  end

  // shot bit low while shot converts
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      shot_req <= 1'b0;
      shot_rd <= MODE_RESET[15];
    end else begin
      shot_req <= shot_set | (shot_req & ~shot_take & pd);
      if (shot_take) shot_rd <= 1'b0;
      else if (conv_fin & shot_busy) shot_rd <= 1'b1;
    end
  end

  // ==========================================================
  // result store, limit compare, fault queue, flag
  logic [2:0] fq;
  logic alert;
  logic int_flag;

  // limits read in the active format
  wire signed [12:0] up_cnt = to_count(upper_limit, wide);
  wire signed [12:0] lo_cnt = to_count(lower_limit, wide);
  wire hi_fault = conv_value >= up_cnt;
  wire lo_fault = conv_value < lo_cnt;
  wire trig = alert ? lo_fault : hi_fault;
  wire [2:0] need = fault_need(fault_sel);
  wire fq_hit = conv_fin & trig & ((fq + 3'h1) >= need);
  wire int_clr = ev_read | ev_ar | pd_rise;
  wire active = tm ? int_flag : alert;
  wire flag_status = flag_pin_polarity ? alert : ~alert;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      temperature_result <= 16'h0000;
    end else if (conv_fin) begin
      temperature_result <= to_word(conv_value, wide);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fq <= 3'h0;
      alert <= 1'b0;
    end else if (conv_fin) begin
      fq <= (trig & ~fq_hit) ? fq + 3'h1 : 3'h0;
      alert <= alert ^ fq_hit;
    end
  end

  // interrupt flag, set wins over clear; pin polarity
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      int_flag <= 1'b0;
      flag_out <= 1'b1;
    end else begin
      int_flag <= fq_hit | (int_flag & ~int_clr);
      flag_out <= flag_pin_polarity ? active : ~active;
    end
  end

  // ==========================================================
  // read word capture for the link
  // mode word with fixed resolution
  wire [15:0] mode_word = {shot_rd, RES_FIXED, fault_sel, flag_pin_polarity, tm, pd,
                           rate, flag_status, wide, 4'h0};
  wire [15:0] rd_word = (sel == IDX_TEMP) ? temperature_result :
                        (sel == IDX_MODE) ? mode_word :
                        (sel == IDX_LOW) ? lower_limit : upper_limit;

  // held until the next read event
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_hold <= 16'h0000;
    end else if (ev_read) begin
      rd_hold <= rd_word;
    end
  end

  // ==========================================================
  // checks
  // index selects captured word
  read_temp_sel_a: assert property (@(posedge mclk) disable iff (reset)
    ev_read && sel == IDX_TEMP |=> rd_hold == $past(temperature_result))
    else $error("read of index 0 did not capture result");
  result_fmt_a: assert property (@(posedge mclk) disable iff (reset)
    conv_fin && !wide |=> temperature_result[3:0] == 4'h0)
    else $error("normal result low bits not zero");
  res_fixed_a: assert property (@(posedge mclk) disable iff (reset)
    mode_word[14:13] == 2'h3)
    else $error("resolution bits not fixed");
  // high byte write keeps low byte
  msb_only_a: assert property (@(posedge mclk) disable iff (reset)
    ev_msb && sel == IDX_HIGH |=> upper_limit[7:0] == $past(upper_limit[7:0]))
    else $error("high byte write changed low byte");
  // no start while powered down without shot
  pd_quiet_a: assert property (@(posedge mclk) disable iff (reset)
    st == ST_SLEEP && !shot_req |=> !conv_start)
    else $error("conversion started while powered down");
  // flag edge only at the programmed count
  fault_count_a: assert property (@(posedge mclk) disable iff (reset)
    alert != $past(alert) |-> $past(fq) == need - 3'h1 || $past(fault_sel) != fault_sel)
    else $error("flag changed before fault count reached");
  // shot bit zero during shot conversion
  shot_low_a: assert property (@(posedge mclk) disable iff (reset)
    st == ST_CONV && shot_busy |-> !shot_rd)
    else $error("shot bit high during shot conversion");
  int_clear_a: assert property (@(posedge mclk) disable iff (reset)
    ev_read && !fq_hit |=> !int_flag ##1 (!$past(tm) || flag_out == !$past(flag_pin_polarity)))
    else $error("interrupt flag survived a read");
  // each periodic (non-shot) start enters conversion with timer loaded
  rate_load_a: assert property (@(posedge mclk) disable iff (reset)
    conv_start && !shot_busy |-> st == ST_CONV && timer == $past(period) - TIMER_W'(1))
    else $error("rate timer not loaded at start");

endmodule // tsr_bank

/* File: bench/tsr_host.sv */
// link-side host model issuing index writes, register writes and reads
`timescale 1ns/100ps
module tsr_host (
  input wire logic lk_clk, // link clock
  input wire logic lk_ready, // bank takes an item
  input wire logic [7:0] lk_rd_data, // offered read byte
  output logic lk_start, // transaction start
  output logic lk_read, // start is a read
  output logic lk_wr_valid, // write byte strobe
  output logic [7:0] lk_wr_byte, // write byte
  output logic lk_rd_next, // read byte consumed
  output logic lk_alert_resp // alert response pulse
);
  int stalls = 0;

  // ==========================================================
  // idle levels
  initial begin
    lk_alert_resp = 1'b0;
    lk_start = 1'b0;
    lk_read = 1'b0;
    lk_wr_valid = 1'b0;
    lk_wr_byte = 8'h5a;
    lk_rd_next = 1'b0;
  end

  // ==========================================================
  // handshake tasks
  // wait for ready seen at an edge, bounded
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge lk_clk);
    while (lk_ready !== 1'b1 && n < 60) begin
      @(posedge lk_clk);
      n++;
    end
    if (n >= 60) stalls++;
  endtask

  // one byte held until taken, then data line scrambled
  task automatic put(input logic [7:0] b);
    wait_rdy();
    lk_wr_valid <= 1'b1;
    lk_wr_byte <= b;
    @(posedge lk_clk);
    lk_wr_valid <= 1'b0;
    lk_wr_byte <= ~b;
    repeat (2) @(posedge lk_clk);
  endtask

  task automatic alert_ack();
    wait_rdy();
    lk_alert_resp <= 1'b1;
    @(posedge lk_clk);
    lk_alert_resp <= 1'b0;
    wait_rdy();
  endtask

  task automatic write(input logic [1:0] idx, input logic [15:0] w, input int n);
    wait_rdy();
    lk_start <= 1'b1;
    lk_read <= 1'b0;
    @(posedge lk_clk);
    lk_start <= 1'b0;
    // upper index bits sent as zero
    put({6'h00, idx});
    if (n > 0) put(w[15:8]);
    if (n > 1) put(w[7:0]);
  endtask

  // high byte first, low byte optional
  task automatic read(input logic [1:0] idx, input bit set_idx, input bit both,
                      output logic [15:0] w);
    if (set_idx) write(idx, 16'h0000, 0);
    wait_rdy();
    lk_start <= 1'b1;
    lk_read <= 1'b1;
    @(posedge lk_clk);
    lk_start <= 1'b0;
    lk_read <= 1'b0;
    repeat (2) @(posedge lk_clk);
    wait_rdy();
    w = {lk_rd_data, 8'h00};
    if (both) begin
      lk_rd_next <= 1'b1;
      @(posedge lk_clk);
      lk_rd_next <= 1'b0;
      @(posedge lk_clk);
      w[7:0] = lk_rd_data;
    end
  endtask
endmodule // tsr_host

/* File: bench/testbench.sv */
// self-checking bench for the temperature sensor register bank
`timescale 1ns/100ps
module testbench;
  localparam int RC [4] = '{400, 200, 100, 50};
  localparam logic [15:0] RV [4] = '{16'h0000, 16'h60a0, 16'h4b00, 16'h5000};
  logic mclk = 1'b0;
  logic lk_clk = 1'b0;
  logic reset = 1'b1;
  logic conv_done = 1'b0;
  logic signed [12:0] conv_value = 13'sh0000;
  logic signed [12:0] cur_temp = 13'sd400;
  logic conv_start, flag_out, lk_ready, lk_start, lk_read, lk_wr_valid;
  logic lk_rd_next, lk_alert_resp;
  logic [7:0] lk_rd_data, lk_wr_byte;
  logic [15:0] w;
  int failures = 0;
  int num_checks = 0;
  int n_start = 0;
  int n_done = 0;
  int cycles = 0;

  // ==========================================================
  // clocks, instances, converter model
  always #12.5 mclk = ~mclk;
  always #3 lk_clk = ~lk_clk;

  tsr_bank #(.RATE0_CYC(400), .RATE1_CYC(200), .RATE2_CYC(100), .RATE3_CYC(50)) uut (
    .mclk(mclk), .reset(reset), .conv_done(conv_done), .conv_value(conv_value),
    .conv_start(conv_start), .flag_out(flag_out), .lk_clk(lk_clk), .lk_start(lk_start),
    .lk_read(lk_read), .lk_wr_valid(lk_wr_valid), .lk_wr_byte(lk_wr_byte),
    .lk_rd_next(lk_rd_next), .lk_alert_resp(lk_alert_resp), .lk_ready(lk_ready),
    .lk_rd_data(lk_rd_data));

  tsr_host host (
    .lk_clk(lk_clk), .lk_ready(lk_ready), .lk_rd_data(lk_rd_data), .lk_start(lk_start),
    .lk_read(lk_read), .lk_wr_valid(lk_wr_valid), .lk_wr_byte(lk_wr_byte),
    .lk_rd_next(lk_rd_next), .lk_alert_resp(lk_alert_resp));

  // converter answers each start after 40 cycles
  initial forever begin
    @(posedge mclk);
    if (conv_start === 1'b1) begin
      repeat (39) @(posedge mclk);
      conv_done <= 1'b1;
      conv_value <= cur_temp;
      @(posedge mclk);
      conv_done <= 1'b0;
      conv_value <= ~cur_temp;
      n_done++;
    end
  end

  // cycle count, start count and hang limit
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1) n_start <= n_start + 1;
    if (cycles == 60000) begin
      failures++;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_conv();
    int n0, k;
    n0 = n_done;
    k = 0;
    while (n_done == n0 && k < 1000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 1000) failures++;
    repeat (3) @(posedge mclk);
  endtask

  task automatic wait_start(output int t);
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (conv_start !== 1'b1 && k < 1000);
    t = cycles;
  endtask

  task automatic done(input string name);
    $display("%s done, checks %0d, mismatches %0d", name, num_checks, failures);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    wait_conv();
    chk1(flag_out, 1'b1);
    host.read(2'h0, 1'b0, 1'b0, w);
    chk16(w, 16'h1900);
    host.read(2'h0, 1'b0, 1'b1, w);
    chk16(w, {cur_temp[11:0], 4'h0});
    for (int i = 1; i < 4; i++) begin
      host.read(2'(i), 1'b1, 1'b1, w);
      chk16(w, RV[i]);
    end
    host.write(2'h0, 16'habcd, 2);
    host.write(2'h2, 16'h1230, 2);
    host.read(2'h0, 1'b1, 1'b1, w);
    chk16(w, 16'h1900);
    host.read(2'h2, 1'b1, 1'b1, w);
    chk16(w, 16'h1230);
    host.write(2'h2, 16'h4b00, 2);
    host.write(2'h3, 16'h6a50, 2);
    host.write(2'h3, 16'h7000, 1);
    host.read(2'h3, 1'b1, 1'b1, w);
    chk16(w, 16'h7050);
    host.write(2'h3, 16'h5000, 2);
    done("t_reset");
  endtask

  task automatic t_mode();
    host.write(2'h1, 16'h1aff, 2);
    host.read(2'h1, 1'b1, 1'b1, w);
    chk16(w, 16'h7af0);
    host.write(2'h1, 16'h00a0, 2);
    host.write(2'h1, 16'h0800, 1);
    host.read(2'h1, 1'b1, 1'b1, w);
    chk16(w, 16'h68a0);
    done("t_mode");
  endtask

  task automatic t_rate();
    int t0, t1;
    for (int c = 0; c < 4; c++) begin
      host.write(2'h1, {8'h00, 2'(c), 6'h00}, 2);
      wait_start(t0);
      wait_start(t0);
      wait_start(t1);
      chk16(16'(t1 - t0), 16'(RC[c]));
    end
    done("t_rate");
  endtask

  task automatic t_fault();
    int need;
    for (int c = 0; c < 4; c++) begin
      need = (c == 0) ? 1 : (c == 3) ? 6 : 2 * c;
      cur_temp = 13'sd1000;
      host.write(2'h1, {3'b000, 2'(c), 3'b000, 8'ha0}, 2);
      repeat (2) wait_conv();
      cur_temp = 13'sd1280;
      for (int i = 1; i <= need; i++) begin
        wait_conv();
        chk1(flag_out, i < need);
      end
      cur_temp = 13'sd1199;
      for (int i = 1; i <= need; i++) begin
        wait_conv();
        chk1(flag_out, i == need);
      end
    end
    done("t_fault");
  endtask

  task automatic t_polint();
    host.write(2'h1, 16'h00a0, 2);
    cur_temp = 13'sd1280;
    repeat (2) wait_conv();
    chk1(flag_out, 1'b0);
    host.read(2'h1, 1'b1, 1'b1, w);
    chk16(w, 16'h6080);
    host.write(2'h1, 16'h04a0, 2);
    repeat (4) @(posedge mclk);
    chk1(flag_out, 1'b1);
    host.read(2'h1, 1'b1, 1'b1, w);
    chk16(w, 16'h64a0);
    host.write(2'h1, 16'h00a0, 2);
    cur_temp = 13'sd1000;
    repeat (2) wait_conv();
    host.write(2'h1, 16'h02a0, 2);
    cur_temp = 13'sd1300;
    wait_conv();
    chk1(flag_out, 1'b0);
    wait_conv();
    chk1(flag_out, 1'b0);
    host.read(2'h0, 1'b1, 1'b1, w);
    chk16(w, 16'h5140);
    repeat (4) @(posedge mclk);
    chk1(flag_out, 1'b1);
    wait_conv();
    chk1(flag_out, 1'b1);
    cur_temp = 13'sd1000;
    wait_conv();
    chk1(flag_out, 1'b0);
    host.alert_ack();
    repeat (4) @(posedge mclk);
    chk1(flag_out, 1'b1);
    cur_temp = 13'sd1300;
    wait_conv();
    chk1(flag_out, 1'b0);
    host.write(2'h1, 16'h03a0, 2);
    repeat (4) @(posedge mclk);
    chk1(flag_out, 1'b1);
    done("t_polint");
  endtask

  task automatic t_shot();
    int s;
    repeat (150) @(posedge mclk);
    s = n_start;
    repeat (300) @(posedge mclk);
    chk16(16'(n_start - s), 16'h0000);
    host.write(2'h1, 16'h01b0, 2);
    cur_temp = -13'sd8;
    s = n_start;
    host.write(2'h1, 16'h8100, 1);
    host.read(2'h1, 1'b1, 1'b0, w);
    chk16(w, 16'h6100);
    wait_conv();
    host.read(2'h0, 1'b1, 1'b1, w);
    chk16(w, {cur_temp, 3'h1});
    host.read(2'h1, 1'b1, 1'b0, w);
    chk16(w, 16'he100);
    host.write(2'h1, 16'h8100, 1);
    host.read(2'h1, 1'b1, 1'b0, w);
    chk16(w, 16'h6100);
    wait_conv();
    repeat (300) @(posedge mclk);
    chk16(16'(n_start - s), 16'h0002);
    done("t_shot");
  endtask

  // ==========================================================
  // main sequence and verdict
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_mode();
    t_rate();
    t_fault();
    t_polint();
    t_shot();
    chk16(16'(host.stalls), 16'h0000);
    end_sim();
  end
endmodule // testbench
